// file: reading_output_formatter.v
// Contract
// - encoding setting: text, single float or double float; text after reset
// - byte sequence setting normal or reversed for binary; reversed after reset
// - incoming commands are accepted only as ascii text
// - text reading is signed decimal mantissa then signed exponent
// - single reading is 32 bits: sign, 8 exponent, 23 fraction
// - binary sign bit is 0 for positive, 1 for negative
// - double reading is 64 bits in ieee double layout
// - binary string opens with header bytes hash then zero
// - header sent once per conversion, never between readings
// - header order is fixed whatever the byte sequence
// - one terminator byte follows the last reading of a string
// - normal sequence sends byte 1 first, byte 4 or 8 last
// - reversed sequence sends last byte first, byte 1 last
// - text always normal order; reversed setting ignored for text
// - binary string is 2 header, 4 or 8 per reading, 1 terminator
// - readings sent follow the selected measurement function
`timescale 1ns/10ps
`include "reading_fmt_map.vh"
module reading_output_formatter
#(
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW = 2
)
(
	// clock, reset, enable
	input wire clk,
	input wire reset_n,
	input wire ce,
	// settings from the command parser
	input wire fmt_set,
	input wire [1:0] fmt_code,
	input wire order_set,
	input wire byte_sequence_select,
	// incoming command bytes
	input wire [7:0] cmd_byte,
	input wire cmd_valid,
	output reg cmd_accept,
	output reg cmd_reject,
	// readings of one conversion
	input wire rd_valid,
	output wire rd_ready,
	input wire rd_last,
	input wire [31:0] rd_single,
	input wire [63:0] rd_double,
	input wire rd_neg,
	input wire [35:0] rd_mant,
	input wire rd_exp_neg,
	input wire [7:0] rd_exp,
	// byte stream to the host
	output wire [7:0] out_data,
	output wire out_valid,
	input wire out_ready,
	// status
	output wire busy,
	output reg [1:0] fmt_now,
	output reg seq_now
);
	localparam S_IDLE = 7'b000_0001;
	localparam S_HDR0 = 7'b000_0010;
	localparam S_HDR1 = 7'b000_0100;
	localparam S_BODY = 7'b000_1000;
	localparam S_NEXT = 7'b001_0000;
	localparam S_SEP = 7'b010_0000;
	localparam S_TERM = 7'b100_0000;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	reg rst_s1_r;
	reg rst_n_r;

	always @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// settings
	// ----------------------------------------------------------------
	reg [1:0] fmt_r;
	reg seq_r;

	always @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			fmt_r <= `ENC_RESET;
			seq_r <= `SEQ_RESET;
		end
		else if (ce)
		begin
			// unknown encoding codes are dropped
			if (fmt_set && (fmt_code == `ENC_TEXT || fmt_code == `ENC_SINGLE ||
				fmt_code == `ENC_DOUBLE))
				fmt_r <= fmt_code;
			if (order_set)
				seq_r <= byte_sequence_select;
		end
	end

	// ----------------------------------------------------------------
	// command byte check
	// ----------------------------------------------------------------
	always @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			cmd_accept <= 1'b0;
			cmd_reject <= 1'b0;
		end
		else if (ce)
		begin
			// binary output choice never changes how commands are read
			cmd_accept <= cmd_valid && (cmd_byte <= `CHR_ASCII_TOP);
			cmd_reject <= cmd_valid && (cmd_byte > `CHR_ASCII_TOP);
		end
	end

	// ----------------------------------------------------------------
	// framing state
	// ----------------------------------------------------------------
	reg [6:0] state_r;
	reg [6:0] state_nxt;
	reg [3:0] idx_r;
	reg [3:0] idx_nxt;
	reg last_r;
	reg [63:0] word_r;
	reg neg_r;
	reg [35:0] mant_r;
	reg eneg_r;
	reg [7:0] exp_r;
	reg [3:0] nbytes;
	reg [7:0] txt_byte;
	reg [7:0] push_data;
	reg push_valid;
	reg take;
	wire push_ready;
	wire [7:0] bin_byte;
	wire is_text;
	wire pushed;

	assign is_text = (fmt_now == `ENC_TEXT);
	assign pushed = push_valid && push_ready;
	assign rd_ready = (state_r == S_IDLE) || (state_r == S_NEXT);
	assign busy = (state_r != S_IDLE);

	always @*
	begin
		case (fmt_now)
			`ENC_SINGLE: nbytes = `LEN_SINGLE;
			`ENC_DOUBLE: nbytes = `LEN_DOUBLE;
			default: nbytes = `LEN_TEXT;
		endcase
	end

	reading_byte_pick u_pick
	(
		.word(word_r),
		.idx(idx_r),
		.nbytes(nbytes),
		.rev(seq_now && !is_text),
		.byte_out(bin_byte)
	);

	// text characters, always leading character first
	always @*
	begin
		txt_byte = `CHR_ZERO;
		case (idx_r)
			`TXT_SIGN: txt_byte = neg_r ? `CHR_MINUS : `CHR_PLUS;
			`TXT_LEAD: txt_byte = `CHR_ZERO | {4'h0, mant_r[35:32]};
			`TXT_POINT: txt_byte = `CHR_POINT;
			`TXT_EXP: txt_byte = `CHR_EXP;
			`TXT_ESIGN: txt_byte = eneg_r ? `CHR_MINUS : `CHR_PLUS;
			`TXT_EHI: txt_byte = `CHR_ZERO | {4'h0, exp_r[7:4]};
			`TXT_ELO: txt_byte = `CHR_ZERO | {4'h0, exp_r[3:0]};
			default:
			begin
				if (idx_r >= `TXT_FRAC_LO && idx_r <= `TXT_FRAC_HI)
					txt_byte = `CHR_ZERO |
						{4'h0, mant_r[(35 - 4 * (idx_r - 4'h2)) -: 4]};
			end
		endcase
	end

	always @*
	begin
		push_valid = 1'b0;
		push_data = `TERM_BYTE;
		case (state_r)
			S_HDR0:
			begin
				push_valid = 1'b1;
				push_data = `HDR_BYTE0;
			end
			S_HDR1:
			begin
				push_valid = 1'b1;
				push_data = `HDR_BYTE1;
			end
			S_BODY:
			begin
				push_valid = 1'b1;
				push_data = is_text ? txt_byte : bin_byte;
			end
			S_SEP:
			begin
				push_valid = 1'b1;
				push_data = `SEP_BYTE;
			end
			S_TERM:
			begin
				push_valid = 1'b1;
				push_data = `TERM_BYTE;
			end
			default:
			begin
				push_valid = 1'b0;
				push_data = `TERM_BYTE;
			end
		endcase
	end

	always @*
	begin
		state_nxt = state_r;
		idx_nxt = idx_r;
		take = 1'b0;
		case (state_r)
			S_IDLE:
			begin
				if (rd_valid)
				begin
					take = 1'b1;
					idx_nxt = 4'h0;
					// header only at the start of a conversion
					state_nxt = (fmt_r == `ENC_TEXT) ? S_BODY : S_HDR0;
				end
			end
			S_HDR0:
				if (pushed)
					state_nxt = S_HDR1;
			S_HDR1:
				if (pushed)
					state_nxt = S_BODY;
			S_BODY:
			begin
				if (pushed)
				begin
					idx_nxt = idx_r + 4'h1;
					if (idx_r == nbytes - 4'h1)
					begin
						idx_nxt = 4'h0;
						state_nxt = last_r ? S_TERM : S_NEXT;
					end
				end
			end
			S_NEXT:
			begin
				// later readings of the string carry no header
				if (rd_valid)
				begin
					take = 1'b1;
					state_nxt = is_text ? S_SEP : S_BODY;
				end
			end
			S_SEP:
				if (pushed)
					state_nxt = S_BODY;
			S_TERM:
				if (pushed)
					state_nxt = S_IDLE;
			default:
				state_nxt = S_IDLE;
		endcase
	end

	always @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			state_r <= S_IDLE;
			idx_r <= 4'h0;
			last_r <= 1'b0;
			word_r <= 64'h0000_0000_0000_0000;
			neg_r <= 1'b0;
			mant_r <= 36'h0_0000_0000;
			eneg_r <= 1'b0;
			exp_r <= 8'h00;
			fmt_now <= `ENC_RESET;
			seq_now <= `SEQ_RESET;
		end
		else if (ce)
		begin
			state_r <= state_nxt;
			idx_r <= idx_nxt;
			if (take)
			begin
				// the function in force decides how many readings come
				last_r <= rd_last;
				neg_r <= rd_neg;
				mant_r <= rd_mant;
				eneg_r <= rd_exp_neg;
				exp_r <= rd_exp;
				if (state_r == S_IDLE)
				begin
					// settings frozen for the whole string
					fmt_now <= fmt_r;
					seq_now <= seq_r;
				end
				if ((state_r == S_IDLE ? fmt_r : fmt_now) == `ENC_DOUBLE)
					word_r <= {rd_neg, rd_double[62:0]};
				else
					word_r <= {32'h0000_0000, rd_neg, rd_single[30:0]};
			end
		end
	end

	// ----------------------------------------------------------------
	// output buffer
	// ----------------------------------------------------------------
	// a stalled host backs up into the framer, never drops bytes
	byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo
	(
		.clk(clk),
		.rst_n(rst_n_r),
		.ce(ce),
		.in_data(push_data),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.out_data(out_data),
		.out_valid(out_valid),
		.out_ready(out_ready)
	);
endmodule

// file: reading_fmt_map.vh
`ifndef READING_FMT_MAP_VH
`define READING_FMT_MAP_VH

// encoding choices
`define ENC_TEXT 2'h0
`define ENC_SINGLE 2'h1
`define ENC_DOUBLE 2'h2
`define ENC_RESET `ENC_TEXT

// byte sequence choices
`define SEQ_NORMAL 1'b0
`define SEQ_REVERSED 1'b1
`define SEQ_RESET `SEQ_REVERSED

// string framing bytes
`define HDR_BYTE0 8'h23
`define HDR_BYTE1 8'h30
`define TERM_BYTE 8'h0A
`define SEP_BYTE 8'h2C

// text characters
`define CHR_PLUS 8'h2B
`define CHR_MINUS 8'h2D
`define CHR_POINT 8'h2E
`define CHR_EXP 8'h45
`define CHR_ZERO 8'h30
`define CHR_ASCII_TOP 8'h7F

// bytes per reading
`define LEN_TEXT 4'hF
`define LEN_SINGLE 4'h4
`define LEN_DOUBLE 4'h8

// text field positions
`define TXT_SIGN 4'h0
`define TXT_LEAD 4'h1
`define TXT_POINT 4'h2
`define TXT_FRAC_LO 4'h3
`define TXT_FRAC_HI 4'hA
`define TXT_EXP 4'hB
`define TXT_ESIGN 4'hC
`define TXT_EHI 4'hD
`define TXT_ELO 4'hE

// sign bit positions
`define SIGN_SINGLE 31
`define SIGN_DOUBLE 63

`endif

// file: byte_fifo.v
`timescale 1ns/10ps
module byte_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW = 2
)
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	input wire ce,
	// fill side
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	// drain side
	output reg [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0] cnt_r;
	wire push;
	wire pop;

	assign in_ready = (cnt_r != DEPTH);
	assign out_valid = (cnt_r != 0);
	assign push = in_valid && in_ready && ce;
	assign pop = out_valid && out_ready && ce;

	always @*
	begin
		out_data = mem[rp_r];
	end

	always @(posedge clk)
	begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r <= {AW{1'b0}};
			rp_r <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == DEPTH - 1) ? {AW{1'b0}} : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == DEPTH - 1) ? {AW{1'b0}} : rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// file: reading_byte_pick.v
`timescale 1ns/10ps
module reading_byte_pick
(
	// reading and position
	input wire [63:0] word,
	input wire [3:0] idx,
	input wire [3:0] nbytes,
	input wire rev,
	// selected byte
	output wire [7:0] byte_out
);
	wire [3:0] pos;
	wire [63:0] shifted;

	// normal order starts at the most significant byte
	assign pos = rev ? idx : (nbytes - 4'h1 - idx);
	assign shifted = word >> {pos, 3'b000};
	assign byte_out = shifted[7:0];
endmodule

// file: reading_fmt_props.sv
`timescale 1ns/10ps
`include "reading_fmt_map.vh"
module reading_fmt_props
(
	// clock and reset
	input wire clk,
	input wire reset_n,
	input wire ce,
	// watched ports
	input wire [7:0] cmd_byte,
	input wire cmd_valid,
	input wire cmd_accept,
	input wire cmd_reject,
	input wire rd_valid,
	input wire rd_ready,
	input wire [7:0] out_data,
	input wire out_valid,
	input wire out_ready,
	input wire busy,
	input wire [1:0] fmt_now,
	input wire seq_now
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	property p_ok;
		cmd_valid && ce && cmd_byte <= `CHR_ASCII_TOP
			|=> cmd_accept && !cmd_reject;
	endproperty
	a_ok: assert property (p_ok) else $error("text byte not accepted");
	property p_bad;
		cmd_valid && ce && cmd_byte > `CHR_ASCII_TOP
			|=> cmd_reject && !cmd_accept;
	endproperty
	a_bad: assert property (p_bad) else $error("binary byte not refused");
	property p_frst;
		$rose(reset_n) |-> fmt_now == `ENC_RESET;
	endproperty
	a_frst: assert property (p_frst) else $error("encoding reset wrong");
	property p_srst;
		$rose(reset_n) |-> seq_now == `SEQ_RESET;
	endproperty
	a_srst: assert property (p_srst) else $error("sequence reset wrong");
	property p_hold;
		out_valid && !out_ready && ce |=> out_valid && $stable(out_data);
	endproperty
	a_hold: assert property (p_hold) else $error("byte lost in stall");
	property p_idle;
		!busy |-> rd_ready;
	endproperty
	a_idle: assert property (p_idle) else $error("idle but not ready");
	property p_start;
		rd_valid && rd_ready && !busy && ce |-> ##[1:3] out_valid;
	endproperty
	a_start: assert property (p_start) else $error("string did not start");
	property p_cfg;
		busy |=> $stable(fmt_now) && $stable(seq_now);
	endproperty
	a_cfg: assert property (p_cfg) else $error("string setting changed");
	cover property (rd_valid && rd_ready && !busy);
	cover property (cmd_reject);
	cover property (out_valid && !out_ready);
endmodule
bind reading_output_formatter reading_fmt_props i_props
(
	.clk(clk), .reset_n(reset_n), .ce(ce), .cmd_byte(cmd_byte),
	.cmd_valid(cmd_valid), .cmd_accept(cmd_accept),
	.cmd_reject(cmd_reject), .rd_valid(rd_valid), .rd_ready(rd_ready),
	.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
	.busy(busy), .fmt_now(fmt_now), .seq_now(seq_now)
);

// file: host_reader.sv
`timescale 1ns/10ps
module host_reader
(
	// clock
	input wire clk,
	input wire ce,
	// byte stream
	input wire [7:0] out_data,
	input wire out_valid,
	output reg out_ready,
	// stall request
	input wire stall
);
	logic [7:0] got [$];

	initial out_ready = 1'b0;
	// reads on while talking, pausing from one clock after stall goes high until one clock after it is low again
	always @(posedge clk)
	begin
		if (out_valid && out_ready && ce)
			got.push_back(out_data);
		out_ready <= !stall;
	end
endmodule

// file: testbench.sv
`timescale 1ns/10ps
`include "reading_fmt_map.vh"
module testbench;
	logic clk = 0, reset_n = 0, ce = 1, fmt_set = 0, order_set = 0;
	logic byte_sequence_select = 0, cmd_valid = 0, rd_valid = 0;
	logic rd_last = 0, rd_neg = 0, rd_exp_neg = 0, stall = 0;
	logic [1:0] fmt_code = 0;
	logic [7:0] cmd_byte = 0, rd_exp = 0;
	logic [31:0] rd_single = 0;
	logic [63:0] rd_double = 0;
	logic [35:0] rd_mant = 0;
	wire cmd_accept, cmd_reject, rd_ready, out_valid, out_ready, busy;
	wire seq_now;
	wire [7:0] out_data;
	wire [1:0] fmt_now;
	int bad_count = 0, total_checks = 0;
	logic [7:0] exp_q [$];

	always #5 clk = ~clk;

	reading_output_formatter i_dut
	(
		.clk(clk), .reset_n(reset_n), .ce(ce), .fmt_set(fmt_set),
		.fmt_code(fmt_code), .order_set(order_set),
		.byte_sequence_select(byte_sequence_select), .cmd_byte(cmd_byte),
		.cmd_valid(cmd_valid), .cmd_accept(cmd_accept),
		.cmd_reject(cmd_reject), .rd_valid(rd_valid), .rd_ready(rd_ready),
		.rd_last(rd_last), .rd_single(rd_single), .rd_double(rd_double),
		.rd_neg(rd_neg), .rd_mant(rd_mant), .rd_exp_neg(rd_exp_neg),
		.rd_exp(rd_exp), .out_data(out_data), .out_valid(out_valid),
		.out_ready(out_ready), .busy(busy), .fmt_now(fmt_now),
		.seq_now(seq_now)
	);

	host_reader i_host
	(
		.clk(clk), .ce(ce), .out_data(out_data), .out_valid(out_valid),
		.out_ready(out_ready), .stall(stall)
	);

	// --------
	// helpers
	// --------
	task conclude;
	begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask

	task check(input [63:0] got, input [63:0] want);
	begin
		total_checks++;
		if (got !== want)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	end
	endtask

	task timeout;
	begin
		check(64'h0, 64'h1);
		conclude();
	end
	endtask

	task set_mode(input [1:0] f, input s);
	begin
		@(posedge clk);
		fmt_code <= f;
		byte_sequence_select <= s;
		fmt_set <= 1;
		order_set <= 1;
		@(posedge clk);
		fmt_set <= 0;
		order_set <= 0;
	end
	endtask

	// offer one reading and hold it until taken
	task send_rd(input [63:0] w, input neg, input last);
	int n;
	begin
		@(posedge clk);
		rd_double <= w;
		rd_single <= w[31:0];
		rd_neg <= neg;
		rd_last <= last;
		rd_valid <= 1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk);
			if (rd_ready === 1'b1)
				break;
		end
		if (n == 200)
			timeout();
		rd_valid <= 0;
	end
	endtask

	task exp_bin(input [63:0] w, input neg, input [3:0] nb, input rev);
	int i;
	begin
		if (nb == 4)
			w[31] = neg;
		else
			w[63] = neg;
		for (i = 0; i < nb; i++)
			exp_q.push_back(rev ? w[8*i+:8] : w[8*(nb-1-i)+:8]);
	end
	endtask

	task drain;
	int n;
	begin
		// let the taking edge settle so busy is already high
		@(posedge clk);
		for (n = 0; n < 500 && (busy !== 1'b0 || out_valid !== 1'b0); n++)
			@(posedge clk);
		if (n == 500)
			timeout();
		repeat (2) @(posedge clk);
		check(i_host.got.size(), exp_q.size());
		for (n = 0; n < exp_q.size() && n < i_host.got.size(); n++)
			check(i_host.got[n], exp_q[n]);
		exp_q.delete();
		i_host.got.delete();
	end
	endtask

	// ----------
	// scenarios
	// ----------
	task t_cmd;
	begin
		@(posedge clk);
		cmd_byte <= 8'h41;
		cmd_valid <= 1;
		@(posedge clk);
		cmd_byte <= 8'h80;
		#1;
		check(cmd_accept, 1);
		check(cmd_reject, 0);
		@(posedge clk);
		cmd_valid <= 0;
		#1;
		check(cmd_reject, 1);
		check(cmd_accept, 0);
	end
	endtask

	// reset leaves text with reversed order, which text must ignore
	task t_text;
	string s;
	int i;
	begin
		s = "-1.00580000E-01,+2.50000000E+03";
		rd_mant <= 36'h1_0058_0000;
		rd_exp <= 8'h01;
		rd_exp_neg <= 1;
		send_rd(64'h0, 1, 0);
		rd_mant <= 36'h2_5000_0000;
		rd_exp <= 8'h03;
		rd_exp_neg <= 0;
		send_rd(64'h0, 0, 1);
		for (i = 0; i < 31; i++)
			exp_q.push_back(s[i]);
		exp_q.push_back(`TERM_BYTE);
		drain();
	end
	endtask

	task t_single;
	begin
		set_mode(`ENC_SINGLE, `SEQ_NORMAL);
		exp_q.push_back(`HDR_BYTE0);
		exp_q.push_back(`HDR_BYTE1);
		send_rd(64'h4120_ED28, 1, 0);
		send_rd(64'hC000_0001, 0, 1);
		exp_bin(64'h4120_ED28, 1, 4, 0);
		exp_bin(64'hC000_0001, 0, 4, 0);
		exp_q.push_back(`TERM_BYTE);
		drain();
	end
	endtask

	// host stall fills the fifo; a mid string change must wait
	task t_double;
	begin
		set_mode(`ENC_DOUBLE, `SEQ_REVERSED);
		stall <= 1;
		exp_q.push_back(`HDR_BYTE0);
		exp_q.push_back(`HDR_BYTE1);
		send_rd(64'h4024_1DB2_2D0E_5604, 0, 0);
		repeat (20) @(posedge clk);
		check(rd_ready, 0);
		stall <= 0;
		set_mode(`ENC_SINGLE, `SEQ_NORMAL);
		send_rd(64'h3FF0_0000_0000_0001, 1, 1);
		exp_bin(64'h4024_1DB2_2D0E_5604, 0, 8, 1);
		exp_bin(64'h3FF0_0000_0000_0001, 1, 8, 1);
		exp_q.push_back(`TERM_BYTE);
		drain();
		check(fmt_now, `ENC_DOUBLE);
		// code 3 must be dropped, the pending single setting stays
		set_mode(2'h3, `SEQ_NORMAL);
		exp_q.push_back(`HDR_BYTE0);
		exp_q.push_back(`HDR_BYTE1);
		send_rd(64'h0000_0000_3F80_0000, 1, 1);
		exp_bin(64'h0000_0000_3F80_0000, 1, 4, 0);
		exp_q.push_back(`TERM_BYTE);
		drain();
		check(fmt_now, `ENC_SINGLE);
		check(seq_now, `SEQ_NORMAL);
	end
	endtask

	initial
	begin
		repeat (6) @(posedge clk);
		reset_n <= 1;
		repeat (3) @(posedge clk);
		check(fmt_now, `ENC_RESET);
		check(seq_now, `SEQ_RESET);
		t_cmd();
		t_text();
		t_single();
		t_double();
		conclude();
	end
endmodule
